// [core/mic_map.svh]
`ifndef MIC_MAP_SVH
`define MIC_MAP_SVH
// Register addresses (byte addresses on the plain register port)
`define MIC_ADDR_CORE_CTRL   8'h00
`define MIC_ADDR_EDGE_SEL    8'h01
`define MIC_ADDR_PRIM_CTRL1  8'h02
`define MIC_ADDR_PRIM_CTRL2  8'h03
`define MIC_ADDR_SERIAL      8'h04
`define MIC_ADDR_TIMER0      8'h05
`define MIC_ADDR_TIMER1      8'h06
`define MIC_ADDR_TIMER2      8'h07
`define MIC_ADDR_TIMER3      8'h08
`define MIC_ADDR_MISC        8'h09
`define MIC_ADDR_PIN_CFG     8'h0A
// Serial register fields
`define MIC_SER_FLAG_BIT     4
`define MIC_SER_EN_BIT       0
// Timer register fields
`define MIC_TMR_A_FLAG_BIT   5
`define MIC_TMR_P_FLAG_BIT   4
`define MIC_TMR_A_EN_BIT     1
`define MIC_TMR_P_EN_BIT     0
// Misc register: flags 7..4, enables 3..0
`define MIC_MISC_FLAG_LSB    4
`define MIC_MISC_EN_LSB      0
// Edge select codes
`define MIC_EDGE_OFF         2'h0
`define MIC_EDGE_RISE        2'h1
`define MIC_EDGE_FALL        2'h2
`define MIC_EDGE_BOTH        2'h3
// Reset values
`define MIC_RST_REG          8'h00
// Vector table
`define MIC_VEC_BASE         12'h004
`define MIC_VEC_STEP         12'h004
// Number of vectored sources
`define MIC_NUM_VEC          11
`endif

// [core/mic_pkg.sv]
package mic_pkg;
  typedef logic [7:0]  mic_byte_t;
  typedef logic [11:0] mic_pc_t;
  typedef logic [10:0] mic_vec_t;
  typedef enum logic [2:0] {
    MIC_IDLE  = 3'b001,
    MIC_PUSH  = 3'b010,
    MIC_LOAD  = 3'b100
  } mic_state_e;
endpackage

// [core/mic_edge_if.sv]
`timescale 1ns/10ps
interface mic_edge_if;
  logic [3:0] pin_lvl;
  logic [7:0] edge_sel;
  logic [3:0] pin_ok;
  logic [3:0] hit;
  modport det (input pin_lvl, input edge_sel, input pin_ok, output hit);
  modport ctl (output pin_lvl, output edge_sel, output pin_ok, input hit);
endinterface

// [core/mic_edge_det.sv]
`timescale 1ns/10ps
`include "mic_map.svh"
module mic_edge_det (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Pin levels and settings
  mic_edge_if.det  eif
);
  import mic_pkg::*;

  logic [3:0] prev_ff;

  // Previous pin level for edge compare
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prev_ff <= 4'h0;
    end else begin
      prev_ff <= eif.pin_lvl;
    end
  end

  // Edge match per pin, pin must be configured as an input
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      case (eif.edge_sel[2*i +: 2])
        `MIC_EDGE_RISE: eif.hit[i] = eif.pin_ok[i] & eif.pin_lvl[i] & ~prev_ff[i];
        `MIC_EDGE_FALL: eif.hit[i] = eif.pin_ok[i] & ~eif.pin_lvl[i] & prev_ff[i];
        `MIC_EDGE_BOTH: eif.hit[i] = eif.pin_ok[i] & (eif.pin_lvl[i] ^ prev_ff[i]);
        default:        eif.hit[i] = 1'b0;
      endcase
    end
  end
endmodule

// [core/mic_irq_ctrl.sv]
`timescale 1ns/10ps
`include "mic_map.svh"
module mic_irq_ctrl (
  // Clock and reset
  input  wire logic           sys_clk,
  input  wire logic           rst,
  // Register port
  input  wire logic [7:0]     reg_addr,
  input  wire logic [7:0]     reg_wdata,
  input  wire logic           reg_wr,
  input  wire logic           reg_rd,
  output logic [7:0]          reg_rdata,
  // External pins and port setup
  input  wire logic [3:0]     ext_pin,
  input  wire logic [3:0]     port_dir_input,
  input  wire logic [3:0]     pull_high_sel,
  output logic [3:0]          pin_pull_en,
  // Peripheral event pulses
  input  wire logic           conv_done_evt,
  input  wire logic           serial_evt,
  input  wire logic [3:0]     compare_a_evt,
  input  wire logic [3:0]     period_evt,
  input  wire logic [1:0]     tick_evt,
  input  wire logic           eeprom_done_evt,
  input  wire logic           low_voltage_evt,
  // Core handshake
  input  wire logic           instr_boundary,
  input  wire logic           return_from_irq_instr,
  input  wire logic           stack_full,
  input  wire mic_pkg::mic_pc_t next_pc,
  output logic                stack_push,
  output mic_pkg::mic_pc_t    push_data,
  output logic                stack_pop,
  output logic                pc_load,
  output mic_pkg::mic_pc_t    pc_vector,
  output logic                wake_up
);
  import mic_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Source order by vector: pin0, pin1, grp0, pin2, pin3, conv, grp1..4, serial
  function automatic mic_vec_t pick_first(input mic_vec_t req);
    pick_first = req & (~req + 11'h001);
  endfunction

  function automatic logic [3:0] vec_index(input mic_vec_t one_hot);
    vec_index = 4'h0;
    for (int i = `MIC_NUM_VEC - 1; i >= 0; i--) begin
      if (one_hot[i]) begin
        vec_index = 4'(i);
      end
    end
  endfunction

  function automatic logic is_wr(input logic [7:0] a, input logic [7:0] ref_a, input logic wr);
    is_wr = wr & (a == ref_a);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic             global_irq_enable_ff;
  logic [7:0]       pin_edge_select_reg_ff;
  logic [3:0]       pin_irq_flag_ff;
  logic [3:0]       pin_irq_enable_ff;
  logic [3:0]       pin_share_ff;
  logic             conversion_done_flag_ff;
  logic             conversion_done_enable_ff;
  logic             serial_module_flag_ff;
  logic             serial_module_enable_ff;
  logic [4:0]       group_irq_flag_ff;
  logic [4:0]       group_irq_enable_ff;
  logic [3:0]       compare_a_flag_ff;
  logic [3:0]       period_compare_flag_ff;
  logic [3:0]       compare_a_enable_ff;
  logic [3:0]       period_compare_enable_ff;
  logic [3:0]       misc_flag_ff;
  logic [3:0]       misc_enable_ff;
  mic_state_e       state_ff;
  logic [3:0]       svc_idx_ff;
  logic [3:0]       pin_hit;
  logic [4:0]       member_set;
  mic_vec_t         req_vec;
  mic_vec_t         grant;
  mic_vec_t         svc_clr;
  logic             take_irq;

  mic_edge_if eif ();

  assign eif.pin_lvl  = ext_pin;
  assign eif.edge_sel = pin_edge_select_reg_ff;
  assign eif.pin_ok   = pin_irq_enable_ff & pin_share_ff & port_dir_input;

  mic_edge_det u_edge (
    .sys_clk (sys_clk),
    .rst     (rst),
    .eif     (eif)
  );

  assign pin_hit = eif.hit;

  ////////////////////////////////////////////////////////////////////////
  // Request vector, gating and priority
  always_comb begin
    req_vec = {serial_module_flag_ff & serial_module_enable_ff,
               group_irq_flag_ff[4:1] & group_irq_enable_ff[4:1],
               conversion_done_flag_ff & conversion_done_enable_ff,
               pin_irq_flag_ff[3:2] & pin_irq_enable_ff[3:2],
               group_irq_flag_ff[0] & group_irq_enable_ff[0],
               pin_irq_flag_ff[1:0] & pin_irq_enable_ff[1:0]};
  end

  assign grant    = pick_first(req_vec);
  // Stack-full check holds requests pending rather than dropping them
  assign take_irq = (state_ff == MIC_IDLE) & instr_boundary & global_irq_enable_ff
                    & ~stack_full & (|req_vec);
  assign svc_clr  = take_irq ? grant : 11'h000;

  // Member sources feeding each group flag
  always_comb begin
    member_set[0] = (|period_evt[1:0]) | (|compare_a_evt[1:0]);
    member_set[1] = period_evt[2] | compare_a_evt[2];
    member_set[2] = period_evt[3] | compare_a_evt[3];
    member_set[3] = eeprom_done_evt | low_voltage_evt;
    member_set[4] = |tick_evt;
  end

  ////////////////////////////////////////////////////////////////////////
  // Vectoring sequence
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_ff   <= MIC_IDLE;
      svc_idx_ff <= 4'h0;
    end else begin
      case (state_ff)
        MIC_IDLE: begin
          if (take_irq) begin
            state_ff   <= MIC_PUSH;
            svc_idx_ff <= vec_index(grant);
          end
        end
        MIC_PUSH: state_ff <= MIC_LOAD;
        MIC_LOAD: state_ff <= MIC_IDLE;
        default:  state_ff <= MIC_IDLE;
      endcase
    end
  end

  // Core strobes, all registered
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stack_push <= 1'b0;
      push_data  <= 12'h000;
      stack_pop  <= 1'b0;
      pc_load    <= 1'b0;
      pc_vector  <= 12'h000;
    end else begin
      stack_push <= take_irq;
      if (take_irq) begin
        push_data <= next_pc;
      end
      pc_load    <= (state_ff == MIC_PUSH);
      if (state_ff == MIC_PUSH) begin
        pc_vector <= `MIC_VEC_BASE + `MIC_VEC_STEP * {8'h00, svc_idx_ff};
      end
      stack_pop  <= return_from_irq_instr;
    end
  end

  // Wake on any source event; an event whose flag is already set still gives a new wake
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wake_up <= 1'b0;
    end else begin
      wake_up <= (|pin_hit) | conv_done_evt | serial_evt | (|member_set);
    end
  end

  // Pull-high selection is passed through unaffected by interrupt use
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_pull_en <= 4'h0;
    end else begin
      pin_pull_en <= pull_high_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Global enable: software write, cleared on service
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      global_irq_enable_ff <= 1'b0;
    end else if (take_irq) begin
      global_irq_enable_ff <= 1'b0;
    end else if (is_wr(reg_addr, `MIC_ADDR_CORE_CTRL, reg_wr)) begin
      global_irq_enable_ff <= reg_wdata[0];
    end
  end

  // Enables and configuration
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_edge_select_reg_ff    <= `MIC_RST_REG;
      pin_irq_enable_ff         <= 4'h0;
      pin_share_ff              <= 4'h0;
      conversion_done_enable_ff <= 1'b0;
      serial_module_enable_ff   <= 1'b0;
      group_irq_enable_ff       <= 5'h00;
      compare_a_enable_ff       <= 4'h0;
      period_compare_enable_ff  <= 4'h0;
      misc_enable_ff            <= 4'h0;
    end else if (reg_wr) begin
      case (reg_addr)
        `MIC_ADDR_EDGE_SEL: pin_edge_select_reg_ff <= reg_wdata;
        `MIC_ADDR_CORE_CTRL: begin
          group_irq_enable_ff[0] <= reg_wdata[3];
          pin_irq_enable_ff[1:0] <= reg_wdata[2:1];
        end
        `MIC_ADDR_PRIM_CTRL1: begin
          conversion_done_enable_ff <= reg_wdata[3];
          group_irq_enable_ff[3:1]  <= reg_wdata[2:0];
        end
        `MIC_ADDR_PRIM_CTRL2: begin
          group_irq_enable_ff[4] <= reg_wdata[3];
          pin_irq_enable_ff[3:2] <= reg_wdata[2:1];
        end
        `MIC_ADDR_SERIAL: serial_module_enable_ff <= reg_wdata[`MIC_SER_EN_BIT];
        `MIC_ADDR_TIMER0, `MIC_ADDR_TIMER1, `MIC_ADDR_TIMER2, `MIC_ADDR_TIMER3: begin
          compare_a_enable_ff[2'(reg_addr - `MIC_ADDR_TIMER0)] <= reg_wdata[`MIC_TMR_A_EN_BIT];
          period_compare_enable_ff[2'(reg_addr - `MIC_ADDR_TIMER0)] <= reg_wdata[`MIC_TMR_P_EN_BIT];
        end
        `MIC_ADDR_MISC: misc_enable_ff <= reg_wdata[`MIC_MISC_EN_LSB +: 4];
        `MIC_ADDR_PIN_CFG: pin_share_ff <= reg_wdata[3:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Vectored flags: event set beats both service clear and software write
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_irq_flag_ff         <= 4'h0;
      conversion_done_flag_ff <= 1'b0;
      serial_module_flag_ff   <= 1'b0;
      group_irq_flag_ff       <= 5'h00;
    end else begin
      pin_irq_flag_ff <= (pin_irq_flag_ff
        & ~{svc_clr[4:3], svc_clr[1:0]}
        & ~(is_wr(reg_addr, `MIC_ADDR_CORE_CTRL, reg_wr) ? 4'h3 : 4'h0)
        & ~(is_wr(reg_addr, `MIC_ADDR_PRIM_CTRL2, reg_wr) ? 4'hC : 4'h0)
        | (is_wr(reg_addr, `MIC_ADDR_CORE_CTRL, reg_wr) ? {2'b00, reg_wdata[5:4]} : 4'h0)
        | (is_wr(reg_addr, `MIC_ADDR_PRIM_CTRL2, reg_wr) ? {reg_wdata[6:5], 2'b00} : 4'h0))
        | pin_hit;
      if (conv_done_evt) begin
        conversion_done_flag_ff <= 1'b1;
      end else if (svc_clr[5]) begin
        conversion_done_flag_ff <= 1'b0;
      end else if (is_wr(reg_addr, `MIC_ADDR_PRIM_CTRL1, reg_wr)) begin
        conversion_done_flag_ff <= reg_wdata[7];
      end
      if (serial_evt) begin
        serial_module_flag_ff <= 1'b1;
      end else if (svc_clr[10]) begin
        serial_module_flag_ff <= 1'b0;
      end else if (is_wr(reg_addr, `MIC_ADDR_SERIAL, reg_wr)) begin
        serial_module_flag_ff <= reg_wdata[`MIC_SER_FLAG_BIT];
      end
      // Only the group flag is cleared by service; members stay for software
      group_irq_flag_ff <= (group_irq_flag_ff
        & ~{svc_clr[9:6], svc_clr[2]}
        & ~(is_wr(reg_addr, `MIC_ADDR_CORE_CTRL, reg_wr) ? 5'h01 : 5'h00)
        & ~(is_wr(reg_addr, `MIC_ADDR_PRIM_CTRL1, reg_wr) ? 5'h0E : 5'h00)
        & ~(is_wr(reg_addr, `MIC_ADDR_PRIM_CTRL2, reg_wr) ? 5'h10 : 5'h00)
        | (is_wr(reg_addr, `MIC_ADDR_CORE_CTRL, reg_wr) ? {4'h0, reg_wdata[6]} : 5'h00)
        | (is_wr(reg_addr, `MIC_ADDR_PRIM_CTRL1, reg_wr) ? {1'b0, reg_wdata[6:4], 1'b0} : 5'h00)
        | (is_wr(reg_addr, `MIC_ADDR_PRIM_CTRL2, reg_wr) ? {reg_wdata[7], 4'h0} : 5'h00))
        | member_set;
    end
  end

  // Member flags: hardware set, software only clears or posts
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      compare_a_flag_ff      <= 4'h0;
      period_compare_flag_ff <= 4'h0;
      misc_flag_ff           <= 4'h0;
    end else begin
      for (int t = 0; t < 4; t++) begin
        if (compare_a_evt[t]) begin
          compare_a_flag_ff[t] <= 1'b1;
        end else if (is_wr(reg_addr, `MIC_ADDR_TIMER0 + 8'(t), reg_wr)) begin
          compare_a_flag_ff[t] <= reg_wdata[`MIC_TMR_A_FLAG_BIT];
        end
        if (period_evt[t]) begin
          period_compare_flag_ff[t] <= 1'b1;
        end else if (is_wr(reg_addr, `MIC_ADDR_TIMER0 + 8'(t), reg_wr)) begin
          period_compare_flag_ff[t] <= reg_wdata[`MIC_TMR_P_FLAG_BIT];
        end
      end
      misc_flag_ff <= (is_wr(reg_addr, `MIC_ADDR_MISC, reg_wr) ? reg_wdata[`MIC_MISC_FLAG_LSB +: 4] : misc_flag_ff)
                      | {tick_evt[1], tick_evt[0], eeprom_done_evt, low_voltage_evt};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `MIC_ADDR_CORE_CTRL:  reg_rdata <= {1'b0, group_irq_flag_ff[0], pin_irq_flag_ff[1:0],
                                            group_irq_enable_ff[0], pin_irq_enable_ff[1:0], global_irq_enable_ff};
        `MIC_ADDR_EDGE_SEL:   reg_rdata <= pin_edge_select_reg_ff;
        `MIC_ADDR_PRIM_CTRL1: reg_rdata <= {conversion_done_flag_ff, group_irq_flag_ff[3:1],
                                            conversion_done_enable_ff, group_irq_enable_ff[3:1]};
        `MIC_ADDR_PRIM_CTRL2: reg_rdata <= {group_irq_flag_ff[4], pin_irq_flag_ff[3:2], 1'b0,
                                            group_irq_enable_ff[4], pin_irq_enable_ff[3:2], 1'b0};
        `MIC_ADDR_SERIAL:     reg_rdata <= {3'b000, serial_module_flag_ff, 3'b000, serial_module_enable_ff};
        `MIC_ADDR_TIMER0, `MIC_ADDR_TIMER1, `MIC_ADDR_TIMER2, `MIC_ADDR_TIMER3:
          reg_rdata <= {2'b00, compare_a_flag_ff[2'(reg_addr - `MIC_ADDR_TIMER0)],
                        period_compare_flag_ff[2'(reg_addr - `MIC_ADDR_TIMER0)], 2'b00,
                        compare_a_enable_ff[2'(reg_addr - `MIC_ADDR_TIMER0)],
                        period_compare_enable_ff[2'(reg_addr - `MIC_ADDR_TIMER0)]};
        `MIC_ADDR_MISC:       reg_rdata <= {misc_flag_ff, misc_enable_ff};
        `MIC_ADDR_PIN_CFG:    reg_rdata <= {4'h0, pin_share_ff};
        default:              reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule

// [bench/mic_irq_ctrl_properties.sv]
`timescale 1ns/10ps
module mic_irq_ctrl_properties (
  // Clock and reset
  input wire logic             sys_clk,
  input wire logic             rst,
  // Pins and events
  input wire logic [3:0]       pull_high_sel,
  input wire logic [3:0]       pin_pull_en,
  input wire logic             conv_done_evt,
  input wire logic             serial_evt,
  input wire logic [3:0]       compare_a_evt,
  // Core handshake
  input wire logic             return_from_irq_instr,
  input wire logic             stack_full,
  input wire mic_pkg::mic_pc_t next_pc,
  input wire logic             stack_push,
  input wire mic_pkg::mic_pc_t push_data,
  input wire logic             stack_pop,
  input wire logic             pc_load,
  input wire mic_pkg::mic_pc_t pc_vector,
  input wire logic             wake_up
);
  import mic_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////
  // Servicing sequence and its spacing
  property p_load; stack_push |=> pc_load; endproperty
  a_load: assert property (p_load) else $error("vector load missing after push");
  property p_push_data; stack_push |-> push_data == $past(next_pc); endproperty
  a_push_data: assert property (p_push_data) else $error("pushed address wrong");
  property p_vec; pc_load |-> pc_vector[1:0] == 2'h0 && pc_vector inside {[12'h004:12'h02C]}; endproperty
  a_vec: assert property (p_vec) else $error("vector outside table");
  property p_gap; stack_push |=> !stack_push ##1 !stack_push; endproperty
  a_gap: assert property (p_gap) else $error("nested take without re-enable");
  property p_full; stack_full |=> !stack_push; endproperty
  a_full: assert property (p_full) else $error("push while stack full");
  property p_pop; return_from_irq_instr |=> stack_pop; endproperty
  a_pop: assert property (p_pop) else $error("return did not pop");
  ////////////////////////////////////////////////////////////////////////
  // Wake and pull-high follow their causes
  property p_wake; (conv_done_evt || serial_evt || |compare_a_evt) |=> wake_up; endproperty
  a_wake: assert property (p_wake) else $error("event did not wake core");
  // Reset release edge skipped, pull copy was cleared there
  property p_pull; !$past(rst) |-> pin_pull_en == $past(pull_high_sel); endproperty
  a_pull: assert property (p_pull) else $error("pull-high choice lost");
endmodule

bind mic_irq_ctrl mic_irq_ctrl_properties i_props (.sys_clk(sys_clk), .rst(rst), .pull_high_sel(pull_high_sel),
  .pin_pull_en(pin_pull_en), .conv_done_evt(conv_done_evt), .serial_evt(serial_evt), .compare_a_evt(compare_a_evt),
  .return_from_irq_instr(return_from_irq_instr), .stack_full(stack_full), .next_pc(next_pc),
  .stack_push(stack_push), .push_data(push_data), .stack_pop(stack_pop), .pc_load(pc_load),
  .pc_vector(pc_vector), .wake_up(wake_up));

// [bench/mic_core_model.sv]
`timescale 1ns/10ps
module mic_core_model #(
  parameter int DEPTH = 1
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // Pace chosen by the bench
  input  wire logic             slow,
  // Requests from the controller
  input  wire logic             stack_push,
  input  wire logic             stack_pop,
  input  wire logic             pc_load,
  input  wire mic_pkg::mic_pc_t push_data,
  input  wire mic_pkg::mic_pc_t pc_vector,
  // Core state
  output logic                  instr_boundary,
  output logic                  stack_full,
  output mic_pkg::mic_pc_t      next_pc
);
  import mic_pkg::*;
  mic_pc_t    stack_ff [4];
  logic [1:0] depth_ff;
  logic       phase_ff;
  ////////////////////////////////////////////////////////////////////////
  // Program counter runs on, jumps to a vector, resumes from the stack
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      next_pc  <= 12'h100;
      depth_ff <= 2'h0;
      phase_ff <= 1'b0;
    end else begin
      phase_ff <= ~phase_ff;
      if (pc_load) begin
        next_pc <= pc_vector;
      end else if (stack_pop && depth_ff != 2'h0) begin
        next_pc <= stack_ff[depth_ff - 2'h1];
      end else begin
        next_pc <= next_pc + 12'h001;
      end
      if (stack_push) begin
        stack_ff[depth_ff] <= push_data;
        depth_ff           <= depth_ff + 2'h1;
      end else if (stack_pop && depth_ff != 2'h0) begin
        depth_ff <= depth_ff - 2'h1;
      end
    end
  end
  // A slow core offers only every other cycle, so takes can be deferred
  assign instr_boundary = slow ? phase_ff : 1'b1;
  assign stack_full     = (depth_ff == 2'(DEPTH));
endmodule

// [bench/mic_irq_ctrl_bench.sv]
`timescale 1ns/10ps
module mic_irq_ctrl_bench;
  import mic_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst     = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic [7:0]  reg_rdata;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        slow = 1'b0;
  logic [3:0]  ext_pin = 4'h0;
  logic [3:0]  dir_in = 4'h0;
  logic [3:0]  pull_sel = 4'hA;
  logic [14:0] ev = 15'h0000;
  logic        stack_push, stack_pop, pc_load, instr_boundary, stack_full;
  mic_pc_t     next_pc, push_data, pc_vector;
  int          miscompares = 0;
  int          compares = 0;
  int          cyc = 0;
  ////////////////////////////////////////////////////////////////////////
  always #2.5 sys_clk = ~sys_clk;
  mic_irq_ctrl i_mic_irq_ctrl (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_pin(ext_pin), .port_dir_input(dir_in),
    .pull_high_sel(pull_sel), .pin_pull_en(), .conv_done_evt(ev[0]), .serial_evt(ev[1]),
    .compare_a_evt(ev[5:2]), .period_evt(ev[9:6]), .tick_evt(ev[11:10]), .eeprom_done_evt(ev[12]),
    .low_voltage_evt(ev[13]), .instr_boundary(instr_boundary), .return_from_irq_instr(ev[14]),
    .stack_full(stack_full), .next_pc(next_pc), .stack_push(stack_push), .push_data(push_data),
    .stack_pop(stack_pop), .pc_load(pc_load), .pc_vector(pc_vector), .wake_up());
  mic_core_model i_mic_core_model (.sys_clk(sys_clk), .rst(rst), .slow(slow), .stack_push(stack_push),
    .stack_pop(stack_pop), .pc_load(pc_load), .push_data(push_data), .pc_vector(pc_vector),
    .instr_boundary(instr_boundary), .stack_full(stack_full), .next_pc(next_pc));
  ////////////////////////////////////////////////////////////////////////
  task end_sim();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(string name, logic [11:0] seen, logic [11:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Strobes last one cycle; the second edge is the one that takes them
  task wr(logic [7:0] a, logic [7:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(logic [7:0] a, logic [7:0] e);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", 12'(reg_rdata), 12'(e));
  endtask
  task pulse(logic [14:0] m);
    @(posedge sys_clk);
    ev <= m;
    @(posedge sys_clk);
    ev <= 15'h0000;
  endtask
  // Bounded wait for the vector load pulse
  task wait_vec(logic [11:0] e);
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      #1 n++;
    end while (pc_load !== 1'b1 && n < 20);
    // A wait that runs out must fail even if a stale vector matches
    chk("pc_load", 12'(pc_load), 12'h001);
    chk("pc_vector", pc_vector, e);
  endtask
  task quiet();
    repeat (8) begin
      @(posedge sys_clk);
      #1 chk("pc_load", 12'(pc_load), 12'h000);
    end
  endtask
  task ev_chk(logic [14:0] m, logic [7:0] a1, logic [7:0] e1, logic [7:0] a2, logic [7:0] e2);
    pulse(m);
    rd(a1, e1);
    rd(a2, e2);
    wr(a1, 8'h00);
    wr(a2, 8'h00);
  endtask
  // Hang guard, well above the length of the sequence
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      miscompares++;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    for (int a = 0; a < 11; a++) rd(8'(a), 8'h00);
    wr(8'h04, 8'hFF);
    rd(8'h04, 8'h11);
    quiet();
    for (int a = 5; a < 9; a++) begin
      wr(8'(a), 8'hFF);
      rd(8'(a), 8'h33);
      wr(8'(a), 8'h00);
    end
    wr(8'h09, 8'hFF);
    rd(8'h09, 8'hFF);
    wr(8'h20, 8'hFF);
    rd(8'h20, 8'h00);
    wr(8'h04, 8'h00);
    wr(8'h09, 8'h00);
    // Events latch with global enable off; groups follow members
    ev_chk(15'h0004, 8'h05, 8'h20, 8'h00, 8'h40);
    ev_chk(15'h0200, 8'h08, 8'h10, 8'h02, 8'h20);
    ev_chk(15'h0800, 8'h09, 8'h80, 8'h03, 8'h80);
    ev_chk(15'h1000, 8'h09, 8'h20, 8'h02, 8'h40);
    ev_chk(15'h2000, 8'h09, 8'h10, 8'h02, 8'h40);
    // Two sources at once: conversion outranks serial
    wr(8'h02, 8'h08);
    wr(8'h04, 8'h01);
    pulse(15'h0003);
    rd(8'h02, 8'h88);
    wr(8'h00, 8'h01);
    wait_vec(12'h018);
    rd(8'h00, 8'h00);
    rd(8'h02, 8'h08);
    rd(8'h04, 8'h11);
    pulse(15'h4000);
    wr(8'h00, 8'h01);
    wait_vec(12'h02C);
    rd(8'h04, 8'h01);
    // Stack now full: a posted request waits for the pop
    slow <= 1'b1;
    wr(8'h02, 8'h88);
    wr(8'h00, 8'h01);
    quiet();
    pulse(15'h4000);
    wait_vec(12'h018);
    pulse(15'h4000);
    slow <= 1'b0;
    // Flag without its enable never vectors
    wr(8'h02, 8'h80);
    wr(8'h00, 8'h01);
    quiet();
    wr(8'h02, 8'h00);
    // Pins: 0 rising, 1 falling, 2 both, 3 off
    dir_in <= 4'hF;
    wr(8'h0A, 8'h0F);
    wr(8'h01, 8'h39);
    wr(8'h00, 8'h06);
    wr(8'h03, 8'h06);
    ext_pin <= 4'hF;
    rd(8'h00, 8'h16);
    rd(8'h03, 8'h26);
    wr(8'h00, 8'h06);
    wr(8'h03, 8'h06);
    dir_in <= 4'h0;
    ext_pin <= 4'h0;
    rd(8'h00, 8'h06);
    rd(8'h03, 8'h06);
    dir_in <= 4'hF;
    ext_pin <= 4'hF;
    // Flags from the rising step are cleared no later than the write that returns the global enable
    wr(8'h03, 8'h06);
    wr(8'h00, 8'h07);
    ext_pin <= 4'h0;
    wait_vec(12'h008);
    rd(8'h00, 8'h06);
    rd(8'h03, 8'h26);
    pulse(15'h4000);
    // Group service clears only the group flag; pending pin 2 is dropped first
    wr(8'h03, 8'h00);
    wr(8'h00, 8'h09);
    pulse(15'h0004);
    wait_vec(12'h00C);
    rd(8'h05, 8'h20);
    rd(8'h00, 8'h08);
    end_sim();
  end
endmodule
